// ---- src/wdt_top.sv ----
// watchdog timer with apb register access
// assumes apb master, lf oscillator level synchronous to clk_i, and that
// rst_i is a power-on reset that the watchdog system reset does not drive
//
// Behaviour
// - counter increments on oscillator ticks through the prescaler.
// - prescale code 0 to 7 divides oscillator by 8 up to 1024.
// - counter equal to compare signals overflow, clears, keeps counting.
// - compare zero disables the watchdog; non-zero starts it.
// - overflow after division times compare plus one oscillator periods.
// - with reset enable set, overflow resets the whole system.
// - every overflow sets the overflow flag, reset enabled or not.
// - reset enable clear and irq enabled gives interrupt request instead.
// - writing one to the kick bit clears counter; bit reads zero.
// - sleep stop clear keeps running asleep; set stops it in sleep.
// - watchdog reset is recorded in a readable reset cause flag.
`timescale 1ns/1ps

module wdt_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // oscillator and power mode
   input wire logic lf_osc_i,
   input wire logic sleep_i,
   // system requests
   output logic sys_reset_o,
   output logic wdog_irq_req_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // last prescaler count for a select code
   function automatic logic [9:0] presc_last(input logic [2:0] ps);
      logic [10:0] div;
      // one bit wider so that division 1024 is not lost in the shift
      div = {1'b0, wdt_pkg::WDT_PRESC_BASE} << ps;
      div = div - 11'h001;
      return div[9:0];
   endfunction

   // read data of a register word
   function automatic logic [31:0] read_word(
      input wdt_pkg::wdt_state_s s,
      input logic [7:0] addr
   );
      logic [31:0] d;
      d = 32'h0000_0000;
      case (addr)
         wdt_pkg::WDT_OFS_CONTROL: begin
            d[wdt_pkg::WDT_BIT_RST_EN] = s.ctrl.rst_en;
            d[wdt_pkg::WDT_BIT_OVF_FLAG] = s.ctrl.ovf_flag;
            d[wdt_pkg::WDT_BIT_SLEEP_STOP] = s.ctrl.sleep_stop;
            d[wdt_pkg::WDT_BIT_PS_MSB:0] = s.ctrl.ps;
         end
         wdt_pkg::WDT_OFS_COMPARE: begin
            d[7:0] = s.cmp;
         end
         wdt_pkg::WDT_OFS_CAUSE: begin
            d[wdt_pkg::WDT_BIT_CAUSE] = s.cause;
         end
         wdt_pkg::WDT_OFS_STATUS: begin
            d[wdt_pkg::WDT_BIT_STAT_OVF] = s.stat;
         end
         wdt_pkg::WDT_OFS_MASK: begin
            d[wdt_pkg::WDT_BIT_STAT_OVF] = s.mask;
         end
         wdt_pkg::WDT_OFS_IRQ_EN: begin
            d[wdt_pkg::WDT_BIT_GLOBAL_IE] = s.global_ie;
            d[wdt_pkg::WDT_BIT_WDOG_IE] = s.wdog_ie;
         end
         default: begin
            d = 32'h0000_0000;
         end
      endcase
      return d;
   endfunction

   // true for a mapped offset
   function automatic logic is_mapped(input logic [7:0] addr);
      logic m;
      m = 1'b0;
      case (addr)
         wdt_pkg::WDT_OFS_CONTROL,
         wdt_pkg::WDT_OFS_COMPARE,
         wdt_pkg::WDT_OFS_CAUSE,
         wdt_pkg::WDT_OFS_STATUS,
         wdt_pkg::WDT_OFS_MASK,
         wdt_pkg::WDT_OFS_IRQ_EN: begin
            m = 1'b1;
         end
         default: begin
            m = 1'b0;
         end
      endcase
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   wdt_pkg::wdt_state_s st_ff;
   wdt_pkg::wdt_state_s nxt_st;

   logic access;
   logic commit;
   logic wr;
   logic rd;
   logic enabled;
   logic running;
   logic lf_tick;
   logic wdog_tick;
   logic restart;
   logic kick;
   logic ovf_now;

   always_comb begin
      nxt_st = st_ff;

      // apb: answer in the second access cycle
      access = psel_i & penable_i;
      commit = access & st_ff.pready;
      wr = commit & pwrite_i;
      rd = commit & ~pwrite_i;
      nxt_st.pready = access & ~st_ff.pready;
      nxt_st.pslverr = access & ~st_ff.pready & ~is_mapped(paddr_i);
      if (access & ~st_ff.pready & ~pwrite_i) begin
         nxt_st.prdata = read_word(st_ff, paddr_i);
      end else begin
         nxt_st.prdata = 32'h0000_0000;
      end

      // run conditions
      enabled = st_ff.cmp != wdt_pkg::WDT_COMPARE_OFF;
      running = enabled & ~(sleep_i & st_ff.ctrl.sleep_stop);
      nxt_st.en_prev = enabled;
      restart = enabled & ~st_ff.en_prev;
      kick = wr & (paddr_i == wdt_pkg::WDT_OFS_CONTROL)
         & pwdata_i[wdt_pkg::WDT_BIT_KICK];

      // oscillator rising edge and prescaler
      nxt_st.lf_prev = lf_osc_i;
      lf_tick = lf_osc_i & ~st_ff.lf_prev;
      wdog_tick = 1'b0;
      ovf_now = 1'b0;
      if (restart | kick | ~enabled) begin
         nxt_st.pre = 10'h000;
         nxt_st.cnt = 8'h00;
      end else if (running & lf_tick) begin
         if (st_ff.pre >= presc_last(st_ff.ctrl.ps)) begin
            nxt_st.pre = 10'h000;
            wdog_tick = 1'b1;
         end else begin
            nxt_st.pre = st_ff.pre + 10'h001;
         end
         if (wdog_tick) begin
            // cmp+1 ticks from zero to overflow
            if (st_ff.cnt == st_ff.cmp) begin
               nxt_st.cnt = 8'h00;
               ovf_now = 1'b1;
            end else begin
               nxt_st.cnt = st_ff.cnt + 8'h01;
            end
         end
      end
      nxt_st.ovf = ovf_now;

      // register writes
      if (wr) begin
         case (paddr_i)
            wdt_pkg::WDT_OFS_CONTROL: begin
               // bit 7 and the kick bit are not stored
               nxt_st.ctrl.rst_en = pwdata_i[wdt_pkg::WDT_BIT_RST_EN];
               nxt_st.ctrl.ovf_flag = pwdata_i[wdt_pkg::WDT_BIT_OVF_FLAG];
               nxt_st.ctrl.sleep_stop =
                  pwdata_i[wdt_pkg::WDT_BIT_SLEEP_STOP];
               nxt_st.ctrl.ps = pwdata_i[wdt_pkg::WDT_BIT_PS_MSB:0];
            end
            wdt_pkg::WDT_OFS_COMPARE: begin
               nxt_st.cmp = pwdata_i[7:0];
            end
            wdt_pkg::WDT_OFS_CAUSE: begin
               // write one to clear
               if (pwdata_i[wdt_pkg::WDT_BIT_CAUSE]) begin
                  nxt_st.cause = 1'b0;
               end
            end
            wdt_pkg::WDT_OFS_MASK: begin
               nxt_st.mask = pwdata_i[wdt_pkg::WDT_BIT_STAT_OVF];
            end
            wdt_pkg::WDT_OFS_IRQ_EN: begin
               nxt_st.global_ie = pwdata_i[wdt_pkg::WDT_BIT_GLOBAL_IE];
               nxt_st.wdog_ie = pwdata_i[wdt_pkg::WDT_BIT_WDOG_IE];
            end
            default: begin
            end
         endcase
      end

      // status clears on read
      if (rd & (paddr_i == wdt_pkg::WDT_OFS_STATUS)) begin
         nxt_st.stat = 1'b0;
      end

      // overflow events: sets win over clears
      if (st_ff.ovf) begin
         nxt_st.ctrl.ovf_flag = 1'b1;
         nxt_st.stat = 1'b1;
         if (st_ff.ctrl.rst_en) begin
            nxt_st.cause = 1'b1;
         end
      end

      // outputs
      nxt_st.sys_rst = st_ff.ovf & st_ff.ctrl.rst_en;
      // while asleep the global enable also gates the wake request
      nxt_st.wdog_irq = nxt_st.ctrl.ovf_flag & nxt_st.wdog_ie
         & ~nxt_st.ctrl.rst_en
         & (~sleep_i | nxt_st.global_ie);
      nxt_st.irq = nxt_st.stat & nxt_st.mask;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
         st_ff.ctrl <= wdt_pkg::wdt_ctrl_s'({
            wdt_pkg::WDT_RST_CONTROL[wdt_pkg::WDT_BIT_RST_EN],
            wdt_pkg::WDT_RST_CONTROL[wdt_pkg::WDT_BIT_OVF_FLAG],
            wdt_pkg::WDT_RST_CONTROL[wdt_pkg::WDT_BIT_SLEEP_STOP],
            wdt_pkg::WDT_RST_CONTROL[wdt_pkg::WDT_BIT_PS_MSB:0]});
         st_ff.cmp <= wdt_pkg::WDT_RST_COMPARE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata_o = st_ff.prdata;
   assign pready_o = st_ff.pready;
   assign pslverr_o = st_ff.pslverr;
   assign sys_reset_o = st_ff.sys_rst;
   assign wdog_irq_req_o = st_ff.wdog_irq;
   assign irq_o = st_ff.irq;

endmodule

// ---- inc/wdt_pkg.sv ----
// package of the watchdog block: register map, field layout, reset values
// assumes a 32-bit apb slave with byte addresses, 20 mhz system clock
package wdt_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] WDT_OFS_CONTROL = 8'h00;
   localparam logic [7:0] WDT_OFS_COMPARE = 8'h04;
   localparam logic [7:0] WDT_OFS_CAUSE = 8'h08;
   localparam logic [7:0] WDT_OFS_STATUS = 8'h0c;
   localparam logic [7:0] WDT_OFS_MASK = 8'h10;
   localparam logic [7:0] WDT_OFS_IRQ_EN = 8'h14;

   ////////////////////////////////////////////////////////////////////////
   // control field positions
   localparam int WDT_BIT_RST_EN = 6;
   localparam int WDT_BIT_OVF_FLAG = 5;
   localparam int WDT_BIT_KICK = 4;
   localparam int WDT_BIT_SLEEP_STOP = 3;
   localparam int WDT_BIT_PS_MSB = 2;
   // cause, status, mask and irq enable bits
   localparam int WDT_BIT_CAUSE = 0;
   localparam int WDT_BIT_STAT_OVF = 0;
   localparam int WDT_BIT_GLOBAL_IE = 0;
   localparam int WDT_BIT_WDOG_IE = 1;

   ////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] WDT_RST_CONTROL = 8'h4f;
   localparam logic [7:0] WDT_RST_COMPARE = 8'hff;

   // prescaler: smallest division 8, i.e. shift of 3
   localparam logic [9:0] WDT_PRESC_BASE = 10'h008;
   localparam logic [7:0] WDT_COMPARE_OFF = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // control register layout
   typedef struct packed {
      logic rst_en;
      logic ovf_flag;
      logic sleep_stop;
      logic [2:0] ps;
   } wdt_ctrl_s;

   // whole block state
   typedef struct packed {
      wdt_ctrl_s ctrl;
      logic [7:0] cmp;
      logic [7:0] cnt;
      logic [9:0] pre;
      logic lf_prev;
      logic en_prev;
      logic cause;
      logic stat;
      logic mask;
      logic global_ie;
      logic wdog_ie;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic sys_rst;
      logic wdog_irq;
      logic ovf;
   } wdt_state_s;

endpackage

// ---- bench/wdt_top_checker.sv ----
// checker of the watchdog block: apb answer and system request outputs
// assumes it is bound to wdt_top and sees only its ports
`timescale 1ns/1ps
module wdt_checker (
   // clock, reset and apb
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // system requests
   input wire logic sys_reset_o,
   input wire logic wdog_irq_req_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_rdy; $rose(penable_i) && psel_i |=> pready_o; endproperty
   property p_one; pready_o |=> !pready_o; endproperty
   property p_err; pslverr_o |-> pready_o && psel_i && penable_i; endproperty
   property p_idle; !pready_o |-> prdata_o == 32'h0; endproperty
   property p_ctl;
      pready_o && !pwrite_i && paddr_i == 8'h00 |->
         prdata_o[31:7] == 25'h0 && !prdata_o[4];
   endproperty
   property p_unm; pready_o && paddr_i > 8'h14 |-> pslverr_o; endproperty
   property p_pulse; sys_reset_o |=> !sys_reset_o; endproperty
   property p_excl; sys_reset_o |-> !wdog_irq_req_o; endproperty
   a_rdy: assert property (p_rdy) else $error("apb answer late");
   a_one: assert property (p_one) else $error("ready longer than one");
   a_err: assert property (p_err) else $error("error outside answer");
   a_idle: assert property (p_idle) else $error("read data not zero");
   a_ctl: assert property (p_ctl) else $error("bad ctl");
   a_unm: assert property (p_unm) else $error("unmapped not refused");
   a_pulse: assert property (p_pulse) else $error("reset too long");
   a_excl: assert property (p_excl) else $error("rst and irq");
   c_rst: cover property (sys_reset_o);
   c_req: cover property (wdog_irq_req_o);
   c_irq: cover property (irq_o);
   c_err: cover property (pslverr_o);
endmodule
bind wdt_top wdt_checker chk_u (.clk_i, .rst_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .sys_reset_o,
   .wdog_irq_req_o, .irq_o);

// ---- bench/wdt_top_bench.sv ----
// self-checking bench of the watchdog block
// assumes wdt_pkg and wdt_top; oscillator rises every 4 clocks
`timescale 1ns/1ps
module wdt_top_bench;
   localparam logic [7:0] CTL = wdt_pkg::WDT_OFS_CONTROL;
   localparam logic [7:0] CMP = wdt_pkg::WDT_OFS_COMPARE;
   localparam logic [7:0] CAU = wdt_pkg::WDT_OFS_CAUSE;
   localparam logic [7:0] STA = wdt_pkg::WDT_OFS_STATUS;
   logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic lf_osc_i = 0, sleep_i = 0, rerr;
   logic [1:0] lf_div = 0;
   logic [7:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, rdat;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, sys_reset_o, wdog_irq_req_o, irq_o;
   int err_count = 0, cmp_count = 0, cyc = 0;
   wdt_top dut_u (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .lf_osc_i, .sleep_i,
      .sys_reset_o, .wdog_irq_req_o, .irq_o);
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      lf_div <= lf_div + 2'h1;
      lf_osc_i <= lf_div[1];
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         $display("mismatch at %0t: timeout", $time);
         test_done;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task test_done;
      $display("compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 16);
      if (pready_o !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: no apb answer", $time);
      end
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s %h/%h", $time, m, got, exp);
      end
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk(rdat, e, "read");
   endtask
   // cycles from the enabling write to the selected output
   task wait_ev(input logic sel, input int lo, input int hi);
      int n;
      n = 0;
      while ((sel ? sys_reset_o : irq_o) !== 1'b1 && n <= hi) begin
         @(posedge clk_i);
         n++;
      end
      cmp_count++;
      if (n < lo || n > hi) begin
         err_count++;
         $display("mismatch at %0t: event after %0d", $time, n);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 0;
      rdc(CTL, 32'h4f);
      rdc(CMP, 32'hff);
      apb(0, 8'h18, 0);
      chk(rdat, 0, "unmapped data");
      chk({31'h0, rerr}, 32'h1, "unmapped error");
      apb(1, CTL, 32'hff);
      rdc(CTL, 32'h6f);
      $display("registers done");
      apb(1, CMP, 0);
      apb(1, CTL, 32'h40);
      apb(1, CMP, 1);
      wait_ev(1, 60, 76);
      rdc(CTL, 32'h60);
      apb(1, CMP, 0);
      rdc(CAU, 1);
      apb(1, CAU, 1);
      rdc(CAU, 0);
      $display("system reset done");
      apb(1, 8'h10, 1);
      for (int p = 0; p < 8; p++) begin
         apb(1, CMP, 0);
         apb(1, CTL, p);
         apb(0, STA, 0);
         apb(1, CMP, 1);
         wait_ev(0, 64 * (1 << p) - 4, 64 * (1 << p) + 12);
         rdc(STA, 1);
         repeat (2) @(posedge clk_i);
         chk(irq_o, 0, "status clear");
      end
      $display("prescale done");
      apb(1, CMP, 0);
      apb(1, 8'h10, 0);
      apb(1, 8'h14, 3);
      apb(1, CTL, 0);
      apb(1, CMP, 1);
      repeat (90) @(posedge clk_i);
      chk({irq_o, wdog_irq_req_o}, 2'b01, "masked");
      apb(1, 8'h14, 2);
      sleep_i <= 1;
      repeat (2) @(posedge clk_i);
      chk(wdog_irq_req_o, 0, "global off asleep");
      sleep_i <= 0;
      apb(1, 8'h14, 3);
      apb(1, 8'h10, 1);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1, "unmasked");
      apb(1, CMP, 0);
      apb(1, CTL, 0);
      repeat (2) @(posedge clk_i);
      chk(wdog_irq_req_o, 0, "flag clear");
      $display("interrupt done");
      apb(0, STA, 0);
      apb(1, CMP, 1);
      repeat (6) begin
         repeat (20) @(posedge clk_i);
         apb(1, CTL, 32'h10);
      end
      chk(irq_o, 0, "kick");
      rdc(CTL, 0);
      apb(1, CTL, 32'h08);
      sleep_i <= 1;
      repeat (150) @(posedge clk_i);
      chk(irq_o, 0, "sleep stop");
      apb(1, CTL, 0);
      repeat (90) @(posedge clk_i);
      chk(irq_o, 1, "sleep run");
      sleep_i <= 0;
      $display("kick and sleep done");
      test_done;
   end
endmodule
